/* File: dtc_defs.vh */
// Contract
// - fast modes: codes pick gear divisions, or low clock for 000/001 if low_freq_sel
// - slow modes: only 000,001,111 give clock
// - event modes count external pin only
// - cascaded modes use channel one select
// - stopped low clock gives no pulses
// - pair enable gates all channel clocks
// - interval mode: op 00/01, no cascade
// - compare holds eight bit match value
// - buffer enable routes running compare writes via holding
// - run starts; mode writes ignored running
// - count, match pulses, clears, continues
// - run cleared stops and zeroes counter
// - channel one behaves identically, independently
// - stop mode clears both run bits
// - cascade/and bits change only stopped
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH
// ************************************
// field positions of the mode register
// ************************************
`define DTC_MOD_DBE      7
`define DTC_MOD_TCK_HI   6
`define DTC_MOD_TCK_LO   4
`define DTC_MOD_EIN      2
`define DTC_MOD_OPM_HI   1
`define DTC_MOD_OPM_LO   0
// ************************************
// field positions of the pair control
// ************************************
`define DTC_CR_OUTPUT_AND_SELECT    3
`define DTC_CR_CAS       2
`define DTC_CR_RUN1      1
`define DTC_CR_RUN0      0
// ************************************
// reset values
// ************************************
`define DTC_MOD_RST      8'h00
`define DTC_CR_RST       4'h0
`define DTC_CNT_RST      8'h00
`define DTC_CMP_RST      8'hFF
// ************************************
// prescaler widths
// ************************************
`define DTC_PRE_W        11
`define DTC_LF_PRE_W     4
`endif

/* File: dtc_timer_pair.v */
`timescale 1ns/1ps
`default_nettype none
`include "dtc_defs.vh"
module dtc_timer_pair (
  input  wire       clock,          // gear clock, 40 MHz
  input  wire       rst_n,          // sync reset, active low
  input  wire       pair_clock_enable, // basic clock gate
  input  wire       low_speed_mode, // low-speed run or sleep
  input  wire       low_freq_sel,   // fast mode: 000/001 use low clock
  input  wire       low_freq_ok,    // low clock oscillating
  input  wire       low_frequency_clock, // low clock, async pin
  input  wire       ext_pin0,       // channel 0 count pin
  input  wire       ext_pin1,       // channel 1 count pin
  input  wire       stop_mode_entry, // pulse: deep stop begins
  input  wire       mod_we0,        // write strobe, mode 0
  input  wire       mod_we1,        // write strobe, mode 1
  input  wire [7:0] mod_wdata,      // mode write data
  input  wire       cmp_we0,        // write strobe, compare 0
  input  wire       cmp_we1,        // write strobe, compare 1
  input  wire [7:0] cmp_wdata,      // compare write data
  input  wire       cr_we,          // write strobe, pair control
  input  wire [3:0] cr_wdata,       // pair control write data
  output reg  [7:0] ch0_mode_register, // mode 0 readback
  output reg  [7:0] ch1_mode_register, // mode 1 readback
  output reg  [7:0] ch0_cmp_written_r, // last written compare 0
  output reg  [7:0] ch1_cmp_written_r, // last written compare 1
  output reg  [3:0] pair_control_register, // control readback
  output reg  [7:0] ch0_count_r,    // channel 0 counter
  output reg  [7:0] ch1_count_r,    // channel 1 counter
  output reg        ch0_match_interrupt, // channel 0 match pulse
  output reg        ch1_match_interrupt  // channel 1 match pulse
);
  // ************************************
  // input synchronisers
  // ************************************
  reg [2:0] sync1_r;                // first stage, read by second only
  reg [2:0] sync2_r;                // second stage
  reg [2:0] prev_r;                 // for edge detection
  // two flops before any logic sees pins
  always @(posedge clock) begin
    if (!rst_n) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
      prev_r  <= 3'h7;
    end else begin
      sync1_r <= {ext_pin1, ext_pin0, low_frequency_clock};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end
  // ************************************
  // prescalers
  // ************************************
  wire       gated = pair_clock_enable; // basic clock present
  wire       lf_rise = sync2_r[0] & ~prev_r[0]; // low clock tick
  wire       pin0_fall = ~sync2_r[1] & prev_r[1]; // falling edge
  wire       pin1_fall = ~sync2_r[2] & prev_r[2];
  reg  [`DTC_PRE_W-1:0]    pre_r;    // gear divider
  reg  [`DTC_LF_PRE_W-1:0] lf_pre_r; // low clock divider
  // dividers clear to zero when gated off
  // gate basic clock
  always @(posedge clock) begin
    if (!rst_n || !gated) begin
      pre_r    <= {`DTC_PRE_W{1'b0}};
      lf_pre_r <= {`DTC_LF_PRE_W{1'b0}};
    end else begin
      pre_r <= pre_r + 1'b1;
      if (lf_rise && low_freq_ok)
        lf_pre_r <= lf_pre_r + 1'b1;
    end
  end
  // one-cycle enable when divider bits below tap are all ones
  function tap_all_ones;
    input [`DTC_PRE_W-1:0] v;
    input integer          n;
    integer                i;
    begin
      tap_all_ones = 1'b1;
      for (i = 0; i < `DTC_PRE_W; i = i + 1)
        if (i < n && !v[i])
          tap_all_ones = 1'b0;
    end
  endfunction
  // source tick per select code and power mode
  function src_tick;
    input [2:0] sel;
    input [`DTC_PRE_W-1:0] pv;
    input [`DTC_LF_PRE_W-1:0] lv;
    input       slow, lfsel, lfr, lfok;
    reg   [`DTC_PRE_W-1:0] lx;
    begin
      lx = {{(`DTC_PRE_W-`DTC_LF_PRE_W){1'b1}}, lv};
      src_tick = 1'b0;
      if (slow) begin
        case (sel)
          3'h0:    src_tick = lfr & lfok & tap_all_ones(lx, 4);
          3'h1:    src_tick = lfr & lfok & tap_all_ones(lx, 3);
          3'h7:    src_tick = lfr & lfok & tap_all_ones(lx, 2);
          default: src_tick = 1'b0;
        endcase
      end else begin
        case (sel)
          3'h0:    src_tick = lfsel ? (lfr & lfok & tap_all_ones(lx, 4)) : tap_all_ones(pv, 11);
          3'h1:    src_tick = lfsel ? (lfr & lfok & tap_all_ones(lx, 3)) : tap_all_ones(pv, 10);
          3'h2:    src_tick = tap_all_ones(pv, 8);
          3'h3:    src_tick = tap_all_ones(pv, 6);
          3'h4:    src_tick = tap_all_ones(pv, 4);
          3'h5:    src_tick = tap_all_ones(pv, 2);
          3'h6:    src_tick = tap_all_ones(pv, 1);
          default: src_tick = 1'b1;
        endcase
      end
    end
  endfunction
  // ************************************
  // per-channel tick selection
  // ************************************
  wire       cas = pair_control_register[`DTC_CR_CAS];
  wire [2:0] ch0_source_clock_select = ch0_mode_register[`DTC_MOD_TCK_HI:`DTC_MOD_TCK_LO];
  wire [2:0] ch1_source_clock_select = ch1_mode_register[`DTC_MOD_TCK_HI:`DTC_MOD_TCK_LO];
  wire [2:0] sel0 = cas ? ch1_source_clock_select : ch0_source_clock_select;
  wire       ch0_external_clock_select = ch0_mode_register[`DTC_MOD_EIN];
  wire       ein1 = ch1_mode_register[`DTC_MOD_EIN];
  wire       int0 = src_tick(sel0, pre_r, lf_pre_r, low_speed_mode, low_freq_sel, lf_rise, low_freq_ok);
  wire       int1 = src_tick(ch1_source_clock_select, pre_r, lf_pre_r, low_speed_mode, low_freq_sel, lf_rise, low_freq_ok);
  wire       tick0 = gated & (ch0_external_clock_select ? pin0_fall : int0);
  wire       tick1 = gated & (ein1 ? pin1_fall : int1);
  wire       mode8_0 = ~ch0_mode_register[`DTC_MOD_OPM_HI] & ~cas;
  wire       mode8_1 = ~ch1_mode_register[`DTC_MOD_OPM_HI] & ~cas;
  // ************************************
  // pair control register
  // ************************************
  wire       run0 = pair_control_register[`DTC_CR_RUN0];
  wire       run1 = pair_control_register[`DTC_CR_RUN1];
  wire       both_stopped = ~run0 & ~run1;
  wire       starting = both_stopped & cr_wdata[`DTC_CR_RUN0] & cr_wdata[`DTC_CR_RUN1];
  // writes need the basic clock, else lost
  always @(posedge clock) begin
    if (!rst_n) begin
      pair_control_register <= `DTC_CR_RST;
    end else if (stop_mode_entry) begin
      pair_control_register[`DTC_CR_RUN1:`DTC_CR_RUN0] <= 2'h0;
    end else if (cr_we && gated) begin
      pair_control_register[`DTC_CR_RUN1:`DTC_CR_RUN0] <= cr_wdata[`DTC_CR_RUN1:`DTC_CR_RUN0];
      if (both_stopped || starting)
        pair_control_register[`DTC_CR_OUTPUT_AND_SELECT:`DTC_CR_CAS] <= cr_wdata[`DTC_CR_OUTPUT_AND_SELECT:`DTC_CR_CAS];
    end
  end
  // ************************************
  // mode registers
  // ************************************
  always @(posedge clock) begin
    if (!rst_n) begin
      ch0_mode_register <= `DTC_MOD_RST;
      ch1_mode_register <= `DTC_MOD_RST;
    end else if (gated) begin
      if (mod_we0 && !run0)
        ch0_mode_register <= mod_wdata;
      if (mod_we1 && !run1)
        ch1_mode_register <= mod_wdata;
    end
  end
  // ************************************
  // compare and counters
  // ************************************
  reg  [7:0] cmp0_r;                // active compare 0
  reg  [7:0] cmp1_r;                // active compare 1
  wire       hit0 = run0 & mode8_0 & tick0 & (ch0_count_r == cmp0_r);
  wire       hit1 = run1 & mode8_1 & tick1 & (ch1_count_r == cmp1_r);
  always @(posedge clock) begin
    if (!rst_n) begin
      ch0_cmp_written_r <= `DTC_CMP_RST;
      ch1_cmp_written_r <= `DTC_CMP_RST;
      cmp0_r            <= `DTC_CMP_RST;
      cmp1_r            <= `DTC_CMP_RST;
    end else begin
      if (cmp_we0 && gated)
        ch0_cmp_written_r <= cmp_wdata;
      if (cmp_we1 && gated)
        ch1_cmp_written_r <= cmp_wdata;
      if (cmp_we0 && gated && (!run0 || !ch0_mode_register[`DTC_MOD_DBE]))
        cmp0_r <= cmp_wdata;
      else if (hit0 && ch0_mode_register[`DTC_MOD_DBE])
        cmp0_r <= ch0_cmp_written_r;
      if (cmp_we1 && gated && (!run1 || !ch1_mode_register[`DTC_MOD_DBE]))
        cmp1_r <= cmp_wdata;
      else if (hit1 && ch1_mode_register[`DTC_MOD_DBE])
        cmp1_r <= ch1_cmp_written_r;
    end
  end
  // counters: count, clear on match, clear on stop
  // channel one mirrors channel zero
  always @(posedge clock) begin
    if (!rst_n) begin
      ch0_count_r         <= `DTC_CNT_RST;
      ch1_count_r         <= `DTC_CNT_RST;
      ch0_match_interrupt <= 1'b0;
      ch1_match_interrupt <= 1'b0;
    end else begin
      ch0_match_interrupt <= hit0;
      ch1_match_interrupt <= hit1;
      if (!run0)
        ch0_count_r <= `DTC_CNT_RST;
      else if (hit0)
        ch0_count_r <= `DTC_CNT_RST;
      else if (tick0 && mode8_0)
        ch0_count_r <= ch0_count_r + 8'h01;
      if (!run1)
        ch1_count_r <= `DTC_CNT_RST;
      else if (hit1)
        ch1_count_r <= `DTC_CNT_RST;
      else if (tick1 && mode8_1)
        ch1_count_r <= ch1_count_r + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: dtc_timer_pair_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// timer pair port checks
// ****
module dtc_timer_pair_sva (
  input wire logic       clock,                 // gear clock
  input wire logic       rst_n,                 // sync reset, low
  input wire logic       pair_clock_enable,     // basic clock gate
  input wire logic       low_speed_mode,        // slow code table
  input wire logic       stop_mode_entry,       // deep stop pulse
  input wire logic       mod_we0,               // mode 0 strobe
  input wire logic [7:0] mod_wdata,             // mode data
  input wire logic       cmp_we0,               // compare 0 strobe
  input wire logic [7:0] cmp_wdata,             // compare data
  input wire logic       cr_we,                 // control strobe
  input wire logic [3:0] cr_wdata,              // control data
  input wire logic [7:0] ch0_mode_register,     // mode 0 readback
  input wire logic [7:0] ch0_cmp_written_r,     // compare 0 readback
  input wire logic [3:0] pair_control_register, // control readback
  input wire logic [7:0] ch0_count_r,           // counter 0
  input wire logic [7:0] ch1_count_r,           // counter 1
  input wire logic       ch0_match_interrupt,   // match pulse 0
  input wire logic       ch1_match_interrupt    // match pulse 1
);
  // one clock domain, so one default for all
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  irq_one_cycle_a: assert property (ch0_match_interrupt |=> !ch0_match_interrupt)
    else $error("match pulse 0 longer than one cycle");
  match_clears_a: assert property (ch0_match_interrupt |-> ch0_count_r == 8'h00)
    else $error("counter 0 not cleared on match");
  ch1_clears_a: assert property (ch1_match_interrupt |-> ch1_count_r == 8'h00)
    else $error("counter 1 not cleared on match");
  stop_zero_a: assert property (!pair_control_register[0] && !$past(pair_control_register[0]) |-> ch0_count_r == 8'h00)
    else $error("stopped counter 0 not zero");
  gate_freeze_a: assert property (!pair_clock_enable && !stop_mode_entry |=> $stable(pair_control_register) && $stable(ch0_count_r))
    else $error("activity while clock gated");
  mode_lock_a: assert property (pair_clock_enable && mod_we0 && pair_control_register[0] |=> $stable(ch0_mode_register))
    else $error("mode 0 changed while running");
  cmp_load_a: assert property (pair_clock_enable && cmp_we0 |=> ch0_cmp_written_r == $past(cmp_wdata))
    else $error("compare 0 readback wrong");
  stop_entry_a: assert property (stop_mode_entry |=> pair_control_register[1:0] == 2'b00)
    else $error("run bits kept after stop entry");
  cas_lock_a: assert property (pair_clock_enable && cr_we && !stop_mode_entry && |pair_control_register[1:0]
    && cr_wdata[1:0] != 2'b11 |=> pair_control_register[3:2] == $past(pair_control_register[3:2]))
    else $error("cascade bits changed while running");
  fast_step_a: assert property (pair_clock_enable && !low_speed_mode && pair_control_register[2:0] == 3'b001
    && ch0_mode_register[6:0] == 7'h70 |=> ch0_count_r == $past(ch0_count_r) + 8'h01 || ch0_count_r == 8'h00)
    else $error("undivided count step wrong");
  irq0_c: cover property (ch0_match_interrupt);
  irq1_c: cover property (ch1_match_interrupt);
  stop_c: cover property (stop_mode_entry && |pair_control_register[1:0]);
endmodule
bind dtc_timer_pair dtc_timer_pair_sva u_sva (.*);
`default_nettype wire

/* File: dtc_timer_pair_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module dtc_timer_pair_tb_top;
  // ****
  // stimulus and observed ports
  // ****
  logic       clock = 1'b0, rst_n = 1'b0, pair_clock_enable = 1'b0, low_speed_mode = 1'b0;
  logic       low_freq_sel = 1'b0, low_freq_ok = 1'b1, low_frequency_clock = 1'b0, ext_pin0 = 1'b1;
  logic       ext_pin1 = 1'b1, stop_mode_entry = 1'b0, mod_we0 = 1'b0, mod_we1 = 1'b0;
  logic       cmp_we0 = 1'b0, cmp_we1 = 1'b0, cr_we = 1'b0, lf_run = 1'b0;
  logic [7:0] mod_wdata = 8'h00, cmp_wdata = 8'h00;
  logic [3:0] cr_wdata = 4'h0;
  logic [7:0] ch0_mode_register, ch1_mode_register, ch0_cmp_written_r, ch1_cmp_written_r, ch0_count_r, ch1_count_r;
  logic [3:0] pair_control_register;
  logic       ch0_match_interrupt, ch1_match_interrupt;
  int         fail_count = 0, total_checks = 0, n;
  // expected match spacing in cycles, compare 1 (two ticks): fast codes then slow codes (0 = no clock)
  // compare 0 on the undivided code would match every cycle and merge the request pulses
  int         per[2][8] = '{'{4096, 2048, 512, 128, 32, 8, 4, 2}, '{128, 64, 0, 0, 0, 0, 0, 32}};
  dtc_timer_pair DUT (.*);
  always #12.5 clock = ~clock;
  // low clock: runs while lf_run is set, 4 gear cycles, toggles on falling gear edges only
  always #50 if (lf_run) low_frequency_clock = ~low_frequency_clock;
  task tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  // one write: 0 mode0, 1 mode1, 2 cmp0, 3 cmp1, 4 control
  task wr(input int sel, input logic [7:0] d);
    tick(1);
    mod_wdata = d;
    cmp_wdata = d;
    cr_wdata = d[3:0];
    {cr_we, cmp_we1, cmp_we0, mod_we1, mod_we0} = 5'h01 << sel;
    tick(1);
    {cr_we, cmp_we1, cmp_we0, mod_we1, mod_we0} = 5'h00;
  endtask
  // cycles until the next match pulse, bounded
  task wirq(input logic ch, output int cnt);
    cnt = 0;
    do begin
      tick(1);
      cnt++;
    end while ((ch ? ch1_match_interrupt : ch0_match_interrupt) !== 1'b1 && cnt < 5000);
  endtask
  task close_out;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog, well beyond the expected run
  initial begin
    #(60000 * 25);
    fail_count++;
    close_out;
  end
  initial begin
    tick(20);
    rst_n = 1'b1;
    `CHK(ch0_cmp_written_r, 8'hFF)
    wr(4, 8'h01);
    `CHK(pair_control_register, 4'h0)
    // enable set once and held high through every run
    pair_clock_enable = 1'b1;
    wr(0, 8'h70);
    wr(2, 8'h02);
    `CHK(ch0_cmp_written_r, 8'h02)
    wr(4, 8'h01);
    wirq(1'b0, n);
    wirq(1'b0, n);
    `CHK(n, 3)
    wr(0, 8'h00);
    `CHK(ch0_mode_register, 8'h70)
    wr(4, 8'h05);
    `CHK(pair_control_register, 4'h1)
    // second channel at half rate while the first keeps going
    wr(1, 8'h60);
    wr(3, 8'h03);
    `CHK(ch1_mode_register, 8'h60)
    `CHK(ch1_cmp_written_r, 8'h03)
    wr(4, 8'h03);
    wirq(1'b1, n);
    wirq(1'b1, n);
    `CHK(n, 8)
    stop_mode_entry = 1'b1;
    tick(1);
    stop_mode_entry = 1'b0;
    `CHK(pair_control_register, 4'h0)
    tick(1);
    `CHK({ch0_count_r, ch1_count_r}, 16'h0000)
    // every source code in both speed tables
    for (int m = 0; m < 2; m++) begin
      low_speed_mode = m[0];
      lf_run = m[0];
      for (int c = 0; c < 8; c++) begin
        wr(0, {1'b0, c[2:0], 4'h0});
        wr(2, 8'h01);
        wr(4, 8'h01);
        if (per[m][c] == 0) begin
          tick(100);
          `CHK(ch0_count_r, 8'h00)
        end else begin
          wirq(1'b0, n);
          wirq(1'b0, n);
          `CHK(n, per[m][c])
        end
        wr(4, 8'h00);
      end
    end
    // low clock chosen while it is dead: no ticks at all
    low_speed_mode = 1'b0;
    lf_run = 1'b0;
    low_freq_ok = 1'b0;
    low_freq_sel = 1'b1;
    wr(0, 8'h00);
    wr(4, 8'h01);
    tick(100);
    `CHK(ch0_count_r, 8'h00)
    wr(4, 8'h00);
    low_freq_sel = 1'b0;
    // pin events only, though the internal code would tick each cycle
    wr(0, 8'h74);
    wr(2, 8'hFF);
    wr(4, 8'h01);
    repeat (3) begin
      ext_pin0 = 1'b0;
      tick(8);
      ext_pin0 = 1'b1;
      tick(8);
    end
    `CHK(ch0_count_r, 8'h03)
    // buffered compare: a write while running waits for the next match
    wr(4, 8'h00);
    wr(0, 8'hF0);
    wr(2, 8'h02);
    wr(4, 8'h01);
    wirq(1'b0, n);
    wr(2, 8'h05);
    `CHK(ch0_cmp_written_r, 8'h05)
    wirq(1'b0, n);
    `CHK(n, 1)
    wirq(1'b0, n);
    `CHK(n, 6)
    // cascade bits land with a write made while both are stopped, then stay
    wr(4, 8'h00);
    wr(4, 8'h07);
    `CHK(pair_control_register, 4'h7)
    tick(10);
    `CHK({ch0_count_r, ch1_count_r}, 16'h0000)
    wr(4, 8'h00);
    `CHK(pair_control_register, 4'h4)
    close_out;
  end
endmodule
`default_nettype wire
